/* logic/pmcc_top.sv */
// power mode and clock controller: modes, wake, clock select, divider, gates
// How it works
// - Writing the idle bit halts the core, peripherals keep clocking, any interrupt resumes.
// - Stop is entered by the stop bit with shutdown-select clear; HF oscillator off, pins held.
// - Stop with shutdown-select set powers the nets down until a reset pin or power-on reset.
// - Snooze is taken only with an HF source selected; it halts clocks and HF and FS oscillators.
// - Snooze ends on timer 4, port match, comparator 0 falling edge or an enabled logic-unit event.
// - In snooze timers 3 and 4 may still tick from the low-frequency oscillator.
// - The regulator sits in low bias during snooze and returns to normal bias on wake.
// - Each peripheral clock is gated off unless software enables it.
// - After reset the system clock is the 24.5 MHz HF output divided by 8.
// - The divider divides the selected source by 1, 2, 4, 8, 16, 32, 64 or 128.
// - The selector picks HF 49 or 24.5, either over 1.5, FS 10 or 2.5, LF 80 kHz or external.
// - Pin hold survives every reset but power-on and is released by software.
// - Two pin interrupts and a 24-pin port match, each with its own request; port match wakes snooze.
`timescale 1ns/1ps
module pmcc_top (
   // clock and power-on reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst_b,
   // other reset sources, synchronous
   input  wire logic                 reset_pin_n,
   input  wire logic                 sys_reset_req,
   // register port
   input  wire logic [3:0]           addr,
   input  wire logic [7:0]           wdata,
   input  wire logic                 wr_stb,
   input  wire logic                 rd_stb,
   output logic      [7:0]           rdata,
   // clock sources and wake inputs
   input  wire pmcc_pkg::pmcc_osc_s  osc_tick,
   input  wire pmcc_pkg::pmcc_wake_s wake_in,
   input  wire logic                 periph_irq,
   // clock enables and power controls
   output pmcc_pkg::pmcc_clkout_s    clk_en,
   output logic                      hf_osc_en,
   output logic                      fs_osc_en,
   output logic                      reg_low_bias,
   output logic                      power_nets_on,
   output logic                      pin_hold,
   // interrupts
   output logic                      irq,
   output logic                      pin_irq_a_req,
   output logic                      pin_irq_b_req,
   output logic                      port_match_req
);
   import pmcc_pkg::*;

   typedef struct packed {
      pmcc_mode_e  mode;
      logic        shdn_sel;
      pmcc_src_e   src;
      logic [2:0]  div;
      logic [7:0]  pclk;
      logic [1:0]  t34_lf;
      logic [7:0]  ev_st;
      logic [7:0]  ev_en;
      logic [23:0] match_val;
      logic [23:0] match_mask;
      logic        hold;
      logic        cmp0_prev;
      logic [1:0]  d15a;
      logic [1:0]  d15b;
      logic [7:0]  rdata;
   } pmcc_state_s;

   localparam pmcc_state_s ST_RST = '{
      mode: MODE_NORMAL, shdn_sel: 1'b0, src: SRC_RST, div: DIV_RST,
      pclk: PCLK_RST, t34_lf: 2'h0, ev_st: 8'h00, ev_en: EN_RST,
      match_val: 24'h000000, match_mask: 24'h000000, hold: 1'b0,
      cmp0_prev: 1'b0, d15a: 2'h0, d15b: 2'h0, rdata: 8'h00};

   pmcc_state_s s_q, s_d;
   logic        src_tick;
   logic        sys_tick;
   logic        hf_ok;
   logic        fs_ok;
   logic        run;
   logic        clk_on;
   logic        match_hit;
   logic        cmp0_fall;
   logic        wake;
   logic        src_is_hf;
   logic [7:0]  ev;
   logic [7:0]  irq_vec;

   // oscillator start-up waits, restarted each time an oscillator is enabled
   // fixed counts stand in for a ready flag the oscillators do not give us
   pmcc_settle #(.CYCLES(HF_SETTLE_CYC)) u_hf_settle (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .en      (hf_osc_en),
      .stable  (hf_ok)
   );

   pmcc_settle #(.CYCLES(FS_SETTLE_CYC)) u_fs_settle (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .en      (fs_osc_en),
      .stable  (fs_ok)
   );

   // source select; the 1.5 taps drop every third HF tick
   // not glitch free: one period may come out short or long after a change
   always_comb begin
      unique case (s_q.src)
         SRC_HF49:     src_tick = osc_tick.hf49;
         SRC_HF24:     src_tick = osc_tick.hf24;
         SRC_HF49_D15: src_tick = osc_tick.hf49 & (s_q.d15a != 2'h2);
         SRC_HF24_D15: src_tick = osc_tick.hf24 & (s_q.d15b != 2'h2);
         SRC_FS10:     src_tick = osc_tick.fs10;
         SRC_FS2P5:    src_tick = osc_tick.fs2p5;
         SRC_LF80:     src_tick = osc_tick.lf;
         SRC_EXT:      src_tick = osc_tick.ext;
      endcase
   end

   pmcc_clk_div u_div (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .tick_in  (src_tick),
      .div_sel  (s_q.div),
      .tick_out (sys_tick)
   );

   // oscillator and power controls follow the mode
   assign hf_osc_en     = (s_q.mode == MODE_NORMAL) || (s_q.mode == MODE_IDLE) ||
                          (s_q.mode == MODE_WAKE);
   assign fs_osc_en     = hf_osc_en || (s_q.mode == MODE_STOP);
   assign reg_low_bias  = (s_q.mode == MODE_SNOOZE);
   assign power_nets_on = (s_q.mode != MODE_SHUTDOWN);
   assign pin_hold      = s_q.hold;

   // clocks: core only in normal, peripherals in normal and idle
   assign run    = (s_q.mode == MODE_NORMAL);
   assign clk_on = run || (s_q.mode == MODE_IDLE);
   assign clk_en.core   = sys_tick & run;
   assign clk_en.periph = {8{sys_tick & clk_on}} & s_q.pclk;
   // timers 3 and 4 keep their low-frequency tick through snooze
   assign clk_en.t3 = s_q.pclk[PERIPH_T3] &
                      (s_q.t34_lf[T34_LF_T3_BIT] ?
                       osc_tick.lf & (clk_on || s_q.mode == MODE_SNOOZE) :
                       sys_tick & clk_on);
   assign clk_en.t4 = s_q.pclk[PERIPH_T4] &
                      (s_q.t34_lf[T34_LF_T4_BIT] ?
                       osc_tick.lf & (clk_on || s_q.mode == MODE_SNOOZE) :
                       sys_tick & clk_on);

   // event detection
   assign match_hit = |((wake_in.port_pins ^ s_q.match_val) & s_q.match_mask);
   assign cmp0_fall = s_q.cmp0_prev & ~wake_in.cmp0;
   assign src_is_hf = (s_q.src == SRC_HF49) || (s_q.src == SRC_HF24) ||
                      (s_q.src == SRC_HF49_D15) || (s_q.src == SRC_HF24_D15);
   // logic-unit events only wake when their interrupt is enabled
   assign wake = wake_in.timer4 | match_hit | cmp0_fall |
                 ((|wake_in.configurable_logic_unit) & s_q.ev_en[EV_CLU]);

   always_comb begin
      ev              = 8'h00;
      ev[EV_PIN_A]    = wake_in.pin_irq_a;
      ev[EV_PIN_B]    = wake_in.pin_irq_b;
      ev[EV_MATCH]    = match_hit;
      ev[EV_TIMER4]   = wake_in.timer4;
      ev[EV_CMP0]     = cmp0_fall;
      ev[EV_CLU]      = |wake_in.configurable_logic_unit;
      ev[EV_WOKE]     = (s_q.mode == MODE_WAKE) && hf_ok && fs_ok;
      ev[EV_REFUSED]  = run && wr_stb && (addr == ADDR_PWR_B) &&
                        wdata[PWR_B_SNOOZE_BIT] && !src_is_hf;
   end

   // interrupt requests, each gated by its enable
   assign irq_vec        = s_q.ev_st & s_q.ev_en;
   assign irq            = |irq_vec;
   assign pin_irq_a_req  = irq_vec[EV_PIN_A];
   assign pin_irq_b_req  = irq_vec[EV_PIN_B];
   assign port_match_req = irq_vec[EV_MATCH];

   // next state: registers, status, mode machine, soft resets
   always_comb begin
      s_d           = s_q;
      s_d.rdata     = 8'h00;
      s_d.cmp0_prev = wake_in.cmp0;
      if (osc_tick.hf49) begin
         s_d.d15a = (s_q.d15a == 2'h2) ? 2'h0 : s_q.d15a + 2'h1;
      end
      if (osc_tick.hf24) begin
         s_d.d15b = (s_q.d15b == 2'h2) ? 2'h0 : s_q.d15b + 2'h1;
      end

      // sticky status: a new event beats a clear in the same cycle
      // so an event in the clearing cycle is never lost to software
      s_d.ev_st = s_q.ev_st;
      if (run && wr_stb && addr == ADDR_IRQ_CLR) begin
         s_d.ev_st = s_q.ev_st & ~wdata;
      end
      s_d.ev_st = s_d.ev_st | ev;

      // the bus only acts while the core runs
      // a halted core cannot issue accesses, so stray strobes are dropped
      if (run && wr_stb) begin
         unique case (addr)
            ADDR_REGU: begin
               s_d.shdn_sel = wdata[REGU_SHDN_BIT];
               if (wdata[REGU_RELEASE_BIT]) begin
                  s_d.hold = 1'b0;
               end
            end
            ADDR_CLKSEL: begin
               s_d.src = pmcc_src_e'(wdata[CLKSEL_SRC_LSB +: 3]);
               s_d.div = wdata[CLKSEL_DIV_LSB +: 3];
            end
            ADDR_PCLK:     s_d.pclk = wdata;
            ADDR_IRQ_EN:   s_d.ev_en = wdata;
            ADDR_T34_LF:   s_d.t34_lf = wdata[1:0];
            ADDR_MATCH_V0: s_d.match_val[7:0] = wdata;
            ADDR_MATCH_V1: s_d.match_val[15:8] = wdata;
            ADDR_MATCH_V2: s_d.match_val[23:16] = wdata;
            ADDR_MATCH_M0: s_d.match_mask[7:0] = wdata;
            ADDR_MATCH_M1: s_d.match_mask[15:8] = wdata;
            ADDR_MATCH_M2: s_d.match_mask[23:16] = wdata;
            default: ;
         endcase
      end

      // read data stand in the cycle after the strobe only
      if (run && rd_stb) begin
         unique case (addr)
            ADDR_REGU:     s_d.rdata = {5'h00, 1'b0, reg_low_bias, s_q.shdn_sel};
            ADDR_CLKSEL:   s_d.rdata = {1'b0, s_q.div, 1'b0, s_q.src};
            ADDR_PCLK:     s_d.rdata = s_q.pclk;
            ADDR_MODE:     s_d.rdata = {1'b0, s_q.hold, fs_ok, hf_ok, 1'b0, s_q.mode};
            ADDR_IRQ_ST:   s_d.rdata = s_q.ev_st;
            ADDR_IRQ_EN:   s_d.rdata = s_q.ev_en;
            ADDR_T34_LF:   s_d.rdata = {6'h00, s_q.t34_lf};
            ADDR_MATCH_V0: s_d.rdata = s_q.match_val[7:0];
            ADDR_MATCH_V1: s_d.rdata = s_q.match_val[15:8];
            ADDR_MATCH_V2: s_d.rdata = s_q.match_val[23:16];
            ADDR_MATCH_M0: s_d.rdata = s_q.match_mask[7:0];
            ADDR_MATCH_M1: s_d.rdata = s_q.match_mask[15:8];
            ADDR_MATCH_M2: s_d.rdata = s_q.match_mask[23:16];
            default:       s_d.rdata = 8'h00;
         endcase
      end

      // mode machine
      unique case (s_q.mode)
         MODE_NORMAL: begin
            if (wr_stb && addr == ADDR_PWR_A && wdata[PWR_A_IDLE_BIT]) begin
               s_d.mode = MODE_IDLE;
            end else if (wr_stb && addr == ADDR_PWR_A && wdata[PWR_A_STOP_BIT]) begin
               // shutdown-select must already be set or clear from an earlier write
               s_d.mode = s_q.shdn_sel ? MODE_SHUTDOWN : MODE_STOP;
               // pins freeze on entry to either stop flavour
               s_d.hold = 1'b1;
            end else if (wr_stb && addr == ADDR_PWR_B && wdata[PWR_B_SNOOZE_BIT] &&
                         src_is_hf) begin
               s_d.mode = MODE_SNOOZE;
            end
         end
         MODE_IDLE: begin
            // periph_irq covers interrupts this block does not collect
            if (irq || periph_irq) begin
               s_d.mode = MODE_NORMAL;
            end
         end
         MODE_SNOOZE: begin
            if (wake) begin
               s_d.mode = MODE_WAKE;
            end
         end
         MODE_WAKE: begin
            // peripherals stay gated as well until both oscillators are stable
            if (hf_ok && fs_ok) begin
               s_d.mode = MODE_NORMAL;
            end
         end
         // stop and shutdown leave only through a reset below
         MODE_STOP:     ;
         MODE_SHUTDOWN: ;
         default:       s_d.mode = MODE_NORMAL;
      endcase

      // pin reset always, other sources except out of shutdown; hold survives
      if (!reset_pin_n || (sys_reset_req && s_q.mode != MODE_SHUTDOWN)) begin
         s_d      = ST_RST;
         s_d.hold = s_q.hold;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         // power-on is the only source that also drops pin hold
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
endmodule

/* logic/pmcc_pkg.sv */
// shared constants, types and carriers of the power mode and clock controller
package pmcc_pkg;

   // clock rate of clk_sys
   localparam int CLK_MHZ = 50;

   // register addresses
   localparam logic [3:0] ADDR_PWR_A     = 4'h0;
   localparam logic [3:0] ADDR_PWR_B     = 4'h1;
   localparam logic [3:0] ADDR_REGU      = 4'h2;
   localparam logic [3:0] ADDR_CLKSEL    = 4'h3;
   localparam logic [3:0] ADDR_PCLK      = 4'h4;
   localparam logic [3:0] ADDR_MODE      = 4'h5;
   localparam logic [3:0] ADDR_IRQ_ST    = 4'h6;
   localparam logic [3:0] ADDR_IRQ_CLR   = 4'h7;
   localparam logic [3:0] ADDR_IRQ_EN    = 4'h8;
   localparam logic [3:0] ADDR_T34_LF    = 4'h9;
   localparam logic [3:0] ADDR_MATCH_V0  = 4'hA;
   localparam logic [3:0] ADDR_MATCH_V1  = 4'hB;
   localparam logic [3:0] ADDR_MATCH_V2  = 4'hC;
   localparam logic [3:0] ADDR_MATCH_M0  = 4'hD;
   localparam logic [3:0] ADDR_MATCH_M1  = 4'hE;
   localparam logic [3:0] ADDR_MATCH_M2  = 4'hF;

   // field positions
   localparam int PWR_A_IDLE_BIT   = 0;
   localparam int PWR_A_STOP_BIT   = 1;
   localparam int PWR_B_SNOOZE_BIT = 0;
   localparam int REGU_SHDN_BIT    = 0;
   localparam int REGU_LOWBIAS_BIT = 1;
   localparam int REGU_RELEASE_BIT = 2;
   localparam int CLKSEL_SRC_LSB   = 0;
   localparam int CLKSEL_DIV_LSB   = 4;
   localparam int MODE_HF_OK_BIT   = 4;
   localparam int MODE_FS_OK_BIT   = 5;
   localparam int MODE_HOLD_BIT    = 6;
   localparam int T34_LF_T3_BIT    = 0;
   localparam int T34_LF_T4_BIT    = 1;
   localparam int PERIPH_T3        = 3;
   localparam int PERIPH_T4        = 4;

   // event bits of the status, clear and enable registers
   localparam int EV_PIN_A    = 0;
   localparam int EV_PIN_B    = 1;
   localparam int EV_MATCH    = 2;
   localparam int EV_TIMER4   = 3;
   localparam int EV_CMP0     = 4;
   localparam int EV_CLU      = 5;
   localparam int EV_WOKE     = 6;
   localparam int EV_REFUSED  = 7;

   // system clock source selection, in field code order
   typedef enum logic [2:0] {
      SRC_HF49, SRC_HF24, SRC_HF49_D15, SRC_HF24_D15,
      SRC_FS10, SRC_FS2P5, SRC_LF80, SRC_EXT
   } pmcc_src_e;

   // power modes
   typedef enum logic [2:0] {
      MODE_NORMAL, MODE_IDLE, MODE_STOP, MODE_SHUTDOWN, MODE_SNOOZE, MODE_WAKE
   } pmcc_mode_e;

   // reset values
   localparam pmcc_src_e  SRC_RST  = SRC_HF24;
   localparam logic [2:0] DIV_RST  = 3'h3;
   localparam logic [7:0] PCLK_RST = 8'h00;
   localparam logic [7:0] EN_RST   = 8'h00;

   // oscillator start-up times and their cycle counts, rounded up
   localparam int HF_SETTLE_NS  = 2000;
   localparam int FS_SETTLE_NS  = 1000;
   localparam int HF_SETTLE_CYC = (HF_SETTLE_NS * CLK_MHZ + 999) / 1000;
   localparam int FS_SETTLE_CYC = (FS_SETTLE_NS * CLK_MHZ + 999) / 1000;

   // one-cycle ticks of each clock source
   typedef struct packed {
      logic hf49;
      logic hf24;
      logic fs10;
      logic fs2p5;
      logic lf;
      logic ext;
   } pmcc_osc_s;

   // wake and interrupt inputs
   typedef struct packed {
      logic        timer4;
      logic        cmp0;
      logic [3:0]  configurable_logic_unit;
      logic        pin_irq_a;
      logic        pin_irq_b;
      logic [23:0] port_pins;
   } pmcc_wake_s;

   // clock enables handed to core and peripherals
   typedef struct packed {
      logic       core;
      logic [7:0] periph;
      logic       t3;
      logic       t4;
   } pmcc_clkout_s;

endpackage

/* logic/pmcc_settle.sv */
// oscillator start-up wait: stable rises a fixed count after enable
`timescale 1ns/1ps
module pmcc_settle #(
   parameter int CYCLES = 100
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // oscillator control
   input  wire logic en,
   output logic      stable
);
   typedef struct packed {
      logic [11:0] cnt;
      logic        stable;
   } pmcc_settle_s;

   pmcc_settle_s s_q, s_d;

   // count up while enabled; any drop restarts the wait
   always_comb begin
      s_d = s_q;
      if (!en) begin
         s_d = '0;
      end else if (!s_q.stable) begin
         if (s_q.cnt == 12'(CYCLES - 1)) begin
            s_d.stable = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 12'h001;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign stable = s_q.stable;
endmodule

/* logic/pmcc_clk_div.sv */
// system clock divider: passes one of every 2^sel source ticks
`timescale 1ns/1ps
module pmcc_clk_div (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // source ticks and setting
   input  wire logic       tick_in,
   input  wire logic [2:0] div_sel,
   output logic            tick_out
);
   typedef struct packed {
      logic [6:0] cnt;
      logic       tick;
   } pmcc_div_s;

   pmcc_div_s  s_q, s_d;
   logic [6:0] lim;

   // limit is 2^sel - 1, so sel 0..7 divides by 1..128
   assign lim = 7'((8'h01 << div_sel) - 8'h01);

   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (tick_in) begin
         if (s_q.cnt >= lim) begin
            s_d.cnt  = 7'h00;
            s_d.tick = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + 7'h01;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_out = s_q.tick;
endmodule

/* tb/pmcc_chk.sv */
// assertion checker on the ports of the power mode and clock controller
`timescale 1ns/1ps
module pmcc_chk
   import pmcc_pkg::*;
(
   // clock, resets and register port
   input wire logic                  clk_sys,
   input wire logic                  rst_b,
   input wire logic                  reset_pin_n,
   input wire logic                  sys_reset_req,
   input wire logic [3:0]            addr,
   input wire logic [7:0]            wdata,
   input wire logic                  wr_stb,
   input wire logic                  rd_stb,
   input wire logic [7:0]            rdata,
   // clock enables and power controls
   input wire pmcc_pkg::pmcc_clkout_s clk_en,
   input wire logic                  hf_osc_en,
   input wire logic                  fs_osc_en,
   input wire logic                  reg_low_bias,
   input wire logic                  power_nets_on,
   input wire logic                  pin_hold,
   // interrupts
   input wire logic                  irq,
   input wire logic                  pin_irq_a_req,
   input wire logic                  pin_irq_b_req,
   input wire logic                  port_match_req
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_rdata_after_read: assert property (rdata != 8'h00 |-> $past(rd_stb))
      else $error("read data outside its slot");
   a_irq_from_req: assert property ((pin_irq_a_req || pin_irq_b_req || port_match_req) |-> irq)
      else $error("request without interrupt line");
   a_snooze_gates: assert property (reg_low_bias |-> !hf_osc_en && !fs_osc_en
      && clk_en.periph == 8'h00 && !clk_en.core) else $error("clocks alive in snooze");
   a_hf_off_core: assert property (!hf_osc_en |-> !clk_en.core)
      else $error("core clocked without oscillator");
   a_snooze_entry: assert property ($rose(reg_low_bias) |-> $past(wr_stb)
      && $past(addr) == ADDR_PWR_B) else $error("low bias without request");
   a_wake_settle: assert property ($fell(reg_low_bias) && $past(reset_pin_n)
      && !$past(sys_reset_req) |-> hf_osc_en && fs_osc_en ##1 !clk_en.core [*8])
      else $error("clocks back before settling");
   a_shdn_entry: assert property ($fell(power_nets_on) |-> $past(wr_stb)
      && $past(addr) == ADDR_PWR_A && $past(wdata[PWR_A_STOP_BIT]))
      else $error("power down without stop request");
   a_shdn_holds: assert property (!power_nets_on && reset_pin_n |=> !power_nets_on
      && pin_hold) else $error("shutdown left without pin reset");

   // main scenarios reached
   c_snooze: cover property ($fell(reg_low_bias));
   c_shdn: cover property ($fell(power_nets_on));
   c_irq: cover property ($rose(irq));
endmodule

/* tb/tb_pmcc_top.sv */
// self-checking bench of the power mode and clock controller
`timescale 1ns/1ps
module tb_pmcc_top;
   import pmcc_pkg::*;
   typedef struct {logic [7:0] sel; logic [5:0] tick; int period;} pmcc_row_s;
   logic       clk_sys, rst_b, reset_pin_n, sys_reset_req, wr_stb, rd_stb, periph_irq;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, d;
   pmcc_osc_s  osc_tick;
   pmcc_wake_s wake_in;
   pmcc_clkout_s clk_en;
   logic       hf_osc_en, fs_osc_en, reg_low_bias, power_nets_on, pin_hold;
   logic       irq, pin_irq_a_req, pin_irq_b_req, port_match_req;
   int         num_errors, checks_done, cycles, i, n, nc, np;
   int         ev_bit [4] = '{EV_TIMER4, EV_MATCH, EV_CMP0, EV_CLU};
   // selector setting, ticking source, expected period in cycles
   pmcc_row_s  rows [10] = '{'{8'h00, 6'h20, 1}, '{8'h11, 6'h10, 2}, '{8'h12, 6'h20, 3},
      '{8'h13, 6'h10, 3}, '{8'h24, 6'h08, 4}, '{8'h35, 6'h04, 8}, '{8'h46, 6'h02, 16},
      '{8'h77, 6'h01, 128}, '{8'h51, 6'h10, 32}, '{8'h61, 6'h10, 64}};

   pmcc_top pmcc_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .reset_pin_n(reset_pin_n),
      .sys_reset_req(sys_reset_req), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .osc_tick(osc_tick), .wake_in(wake_in),
      .periph_irq(periph_irq), .clk_en(clk_en), .hf_osc_en(hf_osc_en),
      .fs_osc_en(fs_osc_en), .reg_low_bias(reg_low_bias), .power_nets_on(power_nets_on),
      .pin_hold(pin_hold), .irq(irq), .pin_irq_a_req(pin_irq_a_req),
      .pin_irq_b_req(pin_irq_b_req), .port_match_req(port_match_req));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      @(negedge clk_sys);
      v = rdata;
   endtask
   // skips two core ticks so a divider mid-count does not skew the figure
   task automatic per(output int p);
      for (int k = 0; k < 3; k++) begin
         p = 0;
         do begin
            @(negedge clk_sys);
            p++;
         end while (clk_en.core !== 1'b1 && p < 400);
      end
   endtask
   task automatic cnt(input int c, output int kc, output int kp);
      kc = 0;
      kp = 0;
      repeat (c) begin
         @(negedge clk_sys);
         kc += int'(clk_en.core === 1'b1);
         kp += int'(clk_en.periph[PERIPH_T4-:2] === 2'b11 || {clk_en.t3, clk_en.t4} === 2'b11);
      end
   endtask
   task automatic pulse_rst;
      @(posedge clk_sys);
      sys_reset_req <= 1'b1;
      @(posedge clk_sys);
      sys_reset_req <= 1'b0;
      @(negedge clk_sys);
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // clock and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         summarize();
      end
   end

   initial begin
      {rst_b, wr_stb, rd_stb, sys_reset_req, periph_irq} = 5'h00;
      reset_pin_n = 1'b1;
      addr = 4'h0;
      wdata = 8'h00;
      osc_tick = pmcc_osc_s'(6'h10);
      wake_in = '0;
      wake_in.cmp0 = 1'b1;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      rd(ADDR_CLKSEL, d);
      chk(d, 8'h31);
      rd(ADDR_PCLK, d);
      chk(d, 8'h00);
      per(n);
      chk(n, 8);
      $display("reset test done");
      for (i = 0; i < 10; i++) begin
         wr(ADDR_CLKSEL, rows[i].sel);
         osc_tick <= pmcc_osc_s'(rows[i].tick);
         rd(ADDR_CLKSEL, d);
         chk(d, rows[i].sel);
         per(n);
         chk(n, rows[i].period);
      end
      $display("clock table done");
      wr(ADDR_CLKSEL, 8'h01);
      osc_tick <= pmcc_osc_s'(6'h12);
      wr(ADDR_PCLK, 8'h18);
      wr(ADDR_PWR_A, 8'h01);
      cnt(20, nc, np);
      chk(nc, 0);
      chk(np, 20);
      @(posedge clk_sys);
      periph_irq <= 1'b1;
      @(posedge clk_sys);
      periph_irq <= 1'b0;
      per(n);
      chk(n, 1);
      $display("idle test done");
      // an enabled pin event raises the line, a masked one only the status
      wr(ADDR_IRQ_EN, 8'h03);
      for (i = 0; i < 2; i++) begin
         @(posedge clk_sys);
         {wake_in.pin_irq_a, wake_in.pin_irq_b} <= 2'b11;
         @(posedge clk_sys);
         {wake_in.pin_irq_a, wake_in.pin_irq_b} <= 2'b00;
         repeat (2) @(negedge clk_sys);
         chk({irq, pin_irq_a_req, pin_irq_b_req}, i == 0 ? 3'b111 : 3'b000);
         rd(ADDR_IRQ_ST, d);
         chk(d[EV_PIN_B:EV_PIN_A], 2'b11);
         wr(ADDR_IRQ_CLR, 8'hFF);
         wr(ADDR_IRQ_EN, 8'h00);
      end
      @(negedge clk_sys);
      chk(irq, 1'b0);
      $display("interrupt test done");
      wr(ADDR_REGU, 8'h00);
      wr(ADDR_PWR_A, 8'h02);
      @(negedge clk_sys);
      chk({hf_osc_en, pin_hold, power_nets_on}, 3'b011);
      pulse_rst();
      chk({hf_osc_en, pin_hold}, 2'b11);
      rd(ADDR_CLKSEL, d);
      chk(d, 8'h31);
      rd(ADDR_MODE, d);
      chk(d, 8'h60);
      wr(ADDR_REGU, 8'h04);
      @(negedge clk_sys);
      chk(pin_hold, 1'b0);
      $display("stop test done");
      wr(ADDR_REGU, 8'h01);
      wr(ADDR_PWR_A, 8'h02);
      @(negedge clk_sys);
      chk({power_nets_on, pin_hold}, 2'b01);
      pulse_rst();
      chk(power_nets_on, 1'b0);
      @(posedge clk_sys);
      reset_pin_n <= 1'b0;
      @(posedge clk_sys);
      reset_pin_n <= 1'b1;
      @(negedge clk_sys);
      chk({power_nets_on, pin_hold}, 2'b11);
      wr(ADDR_REGU, 8'h04);
      $display("shutdown test done");
      // snooze is refused while a fast-start source drives the system clock
      wr(ADDR_CLKSEL, 8'h04);
      wr(ADDR_PWR_B, 8'h01);
      rd(ADDR_IRQ_ST, d);
      chk({d[EV_REFUSED], reg_low_bias}, 2'b10);
      wr(ADDR_CLKSEL, 8'h01);
      wr(ADDR_PCLK, 8'h18);
      wr(ADDR_T34_LF, 8'h03);
      wr(ADDR_MATCH_M0, 8'h01);
      wr(ADDR_IRQ_EN, 8'h24);
      wr(ADDR_IRQ_CLR, 8'hFF);
      for (i = 0; i < 4; i++) begin
         wr(ADDR_PWR_B, 8'h01);
         @(negedge clk_sys);
         chk({reg_low_bias, hf_osc_en, fs_osc_en}, 3'b100);
         cnt(20, nc, np);
         chk(nc, 0);
         chk(np, 20);
         @(posedge clk_sys);
         case (i)
            0: wake_in.timer4 <= 1'b1;
            1: wake_in.port_pins[0] <= 1'b1;
            2: wake_in.cmp0 <= 1'b0;
            default: wake_in.configurable_logic_unit[0] <= 1'b1;
         endcase
         @(posedge clk_sys);
         wake_in.timer4 <= 1'b0;
         wake_in.configurable_logic_unit <= 4'h0;
         n = 0;
         do begin
            @(negedge clk_sys);
            n++;
         end while (reg_low_bias === 1'b1 && n < 4);
         chk({reg_low_bias, hf_osc_en, fs_osc_en}, 3'b011);
         cnt(50, nc, np);
         chk(nc, 0);
         per(n);
         chk(n, 1);
         rd(ADDR_IRQ_ST, d);
         chk({d[EV_WOKE], d[ev_bit[i]], port_match_req}, {2'b11, i == 1});
         @(posedge clk_sys);
         wake_in.port_pins <= '0;
         wake_in.cmp0 <= 1'b1;
         wr(ADDR_IRQ_CLR, 8'hFF);
      end
      $display("snooze test done");
      summarize();
   end
endmodule

bind pmcc_top pmcc_chk pmcc_chk_i (.clk_sys(clk_sys), .rst_b(rst_b),
   .reset_pin_n(reset_pin_n), .sys_reset_req(sys_reset_req), .addr(addr), .wdata(wdata),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .clk_en(clk_en), .hf_osc_en(hf_osc_en),
   .fs_osc_en(fs_osc_en), .reg_low_bias(reg_low_bias), .power_nets_on(power_nets_on),
   .pin_hold(pin_hold), .irq(irq), .pin_irq_a_req(pin_irq_a_req),
   .pin_irq_b_req(pin_irq_b_req), .port_match_req(port_match_req));
